// ==== mbsp_core.sv ====
// Purpose: multibuffer serial port core with per-group hardware triggers
// Assumes: 20 MHz clock; pins and trigger sources asynchronous
// Notes: master clock tops out at half the port clock
`timescale 1ns/1ns
`default_nettype none
module mbsp_core #(
	parameter int NG = 4
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_master,
	input wire logic [mbsp_pkg::MBSP_DIV_W-1:0] i_baud_div,
	input wire mbsp_pkg::mbsp_grp_cfg_t [NG-1:0] i_grp_cfg,
	input wire logic [7:0] i_gio_a,
	input wire logic [5:0] i_timer_ch,
	input wire logic i_tick,
	input wire logic i_buf_wr,
	input wire logic [mbsp_pkg::MBSP_IDX_W-1:0] i_buf_addr,
	input wire logic [1:0] i_buf_field,
	input wire logic [mbsp_pkg::MBSP_WORD_W-1:0] i_buf_wdata,
	input wire logic [mbsp_pkg::MBSP_NUM_PIN-1:0] i_gpio_en,
	input wire logic [mbsp_pkg::MBSP_NUM_PIN-1:0] i_gpio_dir,
	input wire logic [mbsp_pkg::MBSP_NUM_PIN-1:0] i_gpio_out,
	input wire logic [mbsp_pkg::MBSP_NUM_PIN-1:0] i_pin_in,
	output logic [mbsp_pkg::MBSP_NUM_PIN-1:0] o_pin_out,
	output logic [mbsp_pkg::MBSP_NUM_PIN-1:0] o_pin_oe,
	output logic [mbsp_pkg::MBSP_NUM_PIN-1:0] o_pin_sync,
	output logic [mbsp_pkg::MBSP_WORD_W-1:0] o_buf_rdata,
	output logic [NG-1:0] o_grp_done,
	output logic o_busy
);
	import mbsp_pkg::*;
	localparam int GW = (NG > 1) ? $clog2(NG) : 1;
	typedef struct packed {
		mbsp_state_t st;
		logic [NG-1:0] pend;
		logic [NG-1:0] prev;
		logic [NG-1:0] done;
		logic [GW-1:0] grp;
		logic [MBSP_IDX_W-1:0] idx;
		logic [15:0] sh;
		logic [15:0] rx;
		logic [4:0] len;
		logic [4:0] cnt;
		logic cpol;
		logic sclk;
		logic cs_n;
		logic prev_clk;
		logic [MBSP_DIV_W-1:0] div;
		logic [MBSP_NUM_PIN-1:0] pout;
		logic [MBSP_NUM_PIN-1:0] poe;
		logic [15:0] rdata;
		logic busy;
	} mbsp_core_t;
	mbsp_core_t r;
	mbsp_core_t n;
	logic [15:0] mem_tx [0:MBSP_NUM_BUF-1];
	logic [15:0] mem_rx [0:MBSP_NUM_BUF-1];
	logic [15:0] mem_ctrl [0:MBSP_NUM_BUF-1];
	logic [15:0] mem_stat [0:MBSP_NUM_BUF-1];
	logic [MBSP_NUM_SRC-1:0] src_s;
	logic [MBSP_NUM_PIN-1:0] pin_s;
	logic [NG-1:0] sel_lvl;
	logic [NG-1:0] hit;
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Timer channels are taken at the timer boundary, port A after the pad buffer
	mbsp_sync3 #(.W(MBSP_NUM_SRC + MBSP_NUM_PIN)) u_sync (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_async({i_pin_in, i_tick, i_timer_ch, i_gio_a}),
		.o_level({pin_s, src_s})
	);
	// ------------------------------------------------------------
	// Engine
	// ------------------------------------------------------------
	always_comb begin
		logic [NG-1:0] clr;
		logic [GW-1:0] pick;
		logic [4:0] l;
		logic tick;
		logic lead;
		logic trail;
		logic sdi;
		logic edge_s;
		n = r;
		clr = '0;
		pick = '0;
		l = MBSP_LEN_MIN;
		tick = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		edge_s = 1'b0;
		sdi = i_master ? pin_s[MBSP_PIN_SOMI] : pin_s[MBSP_PIN_SIMO];
		n.done = '0;
		n.prev_clk = pin_s[MBSP_PIN_CLK];
		for (int g = 0; g < NG; g++) begin
			if (i_grp_cfg[g].src == MBSP_SRC_NONE) begin
				sel_lvl[g] = 1'b0;
				hit[g] = 1'b0;
			end else begin
				sel_lvl[g] = src_s[i_grp_cfg[g].src - 4'h1];
				hit[g] = i_grp_cfg[g].evt_low ? !sel_lvl[g] : (sel_lvl[g] && !r.prev[g]);
			end
		end
		n.prev = sel_lvl;
		for (int g = NG - 1; g >= 0; g--) begin
			if (r.pend[g]) begin
				pick = GW'(g);
			end
		end
		unique case (r.st)
			MBSP_IDLE: begin
				n.cs_n = 1'b1;
				n.sclk = r.cpol;
				if (|r.pend) begin
					n.grp = pick;
					n.idx = i_grp_cfg[pick].first;
					clr[pick] = 1'b1;
					n.st = MBSP_LOAD;
				end
			end
			MBSP_LOAD: begin
				l = mem_ctrl[r.idx][MBSP_CTRL_LEN_LSB +: 5];
				if (l < MBSP_LEN_MIN) begin
					l = MBSP_LEN_MIN;
				end
				if (l > MBSP_LEN_MAX) begin
					l = MBSP_LEN_MAX;
				end
				n.len = l;
				n.cpol = mem_ctrl[r.idx][MBSP_CTRL_CPOL];
				n.sclk = mem_ctrl[r.idx][MBSP_CTRL_CPOL];
				n.sh = mem_tx[r.idx] << (MBSP_LEN_MAX - l);
				n.rx = '0;
				n.cnt = '0;
				n.div = '0;
				n.cs_n = 1'b0;
				n.st = MBSP_SHIFT;
			end
			MBSP_SHIFT: begin
				if (i_master) begin
					if (r.div == i_baud_div) begin
						n.div = '0;
						n.sclk = ~r.sclk;
						tick = 1'b1;
					end else begin
						n.div = r.div + 8'h01;
					end
					lead = tick && (r.sclk == r.cpol);
					trail = tick && (r.sclk != r.cpol);
				end else begin
					// Slave shifts only on edges of the outside clock while selected
					edge_s = (pin_s[MBSP_PIN_CLK] != r.prev_clk) && !pin_s[MBSP_PIN_CS];
					lead = edge_s && (pin_s[MBSP_PIN_CLK] != r.cpol);
					trail = edge_s && (pin_s[MBSP_PIN_CLK] == r.cpol);
				end
				if (lead) begin
					n.rx = {r.rx[14:0], sdi};
				end
				if (trail) begin
					n.sh = r.sh << 1;
					n.cnt = r.cnt + 5'h01;
					if (r.cnt == r.len - 5'h01) begin
						n.st = MBSP_STORE;
					end
				end
			end
			MBSP_STORE: begin
				if (r.idx == i_grp_cfg[r.grp].last) begin
					n.done[r.grp] = 1'b1;
					n.cs_n = 1'b1;
					n.st = MBSP_IDLE;
				end else begin
					n.idx = r.idx + 7'h01;
					n.st = MBSP_LOAD;
				end
			end
		endcase
		// A trigger in the same cycle as its start re-arms the group
		n.pend = (r.pend & ~clr) | hit;
		n.busy = (n.st != MBSP_IDLE);
		// Pin functions, overridden per pin when handed to general use
		n.pout = '0;
		n.poe = '0;
		if (i_master) begin
			n.pout[MBSP_PIN_CLK] = n.sclk;
			n.poe[MBSP_PIN_CLK] = 1'b1;
			n.pout[MBSP_PIN_SIMO] = n.sh[15];
			n.poe[MBSP_PIN_SIMO] = 1'b1;
			n.pout[MBSP_PIN_CS] = n.cs_n;
			n.poe[MBSP_PIN_CS] = 1'b1;
		end else begin
			n.pout[MBSP_PIN_SOMI] = n.sh[15];
			n.poe[MBSP_PIN_SOMI] = !pin_s[MBSP_PIN_CS];
		end
		n.pout = (n.pout & ~i_gpio_en) | (i_gpio_out & i_gpio_en);
		n.poe = (n.poe & ~i_gpio_en) | (i_gpio_dir & i_gpio_en);
		unique case (i_buf_field)
			MBSP_FLD_TX: n.rdata = mem_tx[i_buf_addr];
			MBSP_FLD_RX: n.rdata = mem_rx[i_buf_addr];
			MBSP_FLD_CTRL: n.rdata = mem_ctrl[i_buf_addr];
			MBSP_FLD_STAT: n.rdata = mem_stat[i_buf_addr];
		endcase
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	// ------------------------------------------------------------
	// Buffer memory
	// ------------------------------------------------------------
	// No reset: contents are undefined until software or the engine fills them
	always_ff @(posedge i_clock) begin
		if (i_buf_wr && i_buf_field == MBSP_FLD_TX) begin
			mem_tx[i_buf_addr] <= i_buf_wdata;
		end
		if (i_buf_wr && i_buf_field == MBSP_FLD_CTRL) begin
			mem_ctrl[i_buf_addr] <= i_buf_wdata;
		end
		if (r.st == MBSP_STORE) begin
			mem_rx[r.idx] <= r.rx;
			mem_stat[r.idx] <= MBSP_STAT_DONE;
		end
		// Completion status wins over a software clear of the same entry
		if (i_buf_wr && i_buf_field == MBSP_FLD_STAT && !(r.st == MBSP_STORE && r.idx == i_buf_addr)) begin
			mem_stat[i_buf_addr] <= i_buf_wdata;
		end
	end
	assign o_pin_out = r.pout;
	assign o_pin_oe = r.poe;
	assign o_pin_sync = pin_s;
	assign o_buf_rdata = r.rdata;
	assign o_grp_done = r.done;
	assign o_busy = r.busy;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	AST_LEN_RANGE: assert property (r.st == MBSP_SHIFT |-> r.len >= 5'h02 && r.len <= 5'h10)
		else $error("word length outside 2..16");
	AST_DIV_STEP: assert property (i_master && r.st == MBSP_SHIFT
		&& $stable(i_baud_div) && r.div != i_baud_div |=> $stable(r.sclk))
		else $error("serial clock toggled before divider expired");
	AST_SLAVE_NO_CLK: assert property (!i_master && !i_gpio_en[0] |=> !o_pin_oe[0])
		else $error("slave drives the serial clock");
	AST_MASTER_CLK: assert property (i_master && !i_gpio_en[0] |=> o_pin_oe[0] && o_pin_out[0] == r.sclk)
		else $error("master not driving the serial clock");
	AST_FORMAT: assert property (r.st == MBSP_LOAD && mem_ctrl[r.idx][4:0] inside {[5'h02:5'h10]}
		|=> r.len == $past(mem_ctrl[r.idx][4:0]))
		else $error("word format not taken from its entry");
	AST_GPIO: assert property (i_gpio_en[1]
		|=> o_pin_out[1] == $past(i_gpio_out[1]) && o_pin_oe[1] == $past(i_gpio_dir[1]))
		else $error("general pin not following its control");
	AST_GROUP_RANGE: assert property (r.st == MBSP_LOAD && $stable(i_grp_cfg)
		|-> r.idx >= i_grp_cfg[r.grp].first && r.idx <= i_grp_cfg[r.grp].last)
		else $error("entry outside active group");
	AST_NO_SRC: assert property (i_grp_cfg[0].src == 4'h0 && $stable(i_grp_cfg[0])
		&& !r.pend[0] |=> !r.pend[0])
		else $error("group without source was triggered");
	AST_EDGE_SET: assert property (i_grp_cfg[0].src != 4'h0 && !i_grp_cfg[0].evt_low
		&& sel_lvl[0] && !r.prev[0] |=> r.pend[0])
		else $error("rising edge did not arm the group");
	AST_LOW_SET: assert property (i_grp_cfg[0].src != 4'h0 && i_grp_cfg[0].evt_low
		&& !sel_lvl[0] |=> r.pend[0])
		else $error("low level did not arm the group");
	AST_DONE_IN_TIME: assert property (r.st == MBSP_STORE
		|-> ##[1:2] (r.st == MBSP_IDLE || r.st == MBSP_SHIFT))
		else $error("engine stalled after a word");
	COV_MASTER_GROUP: cover property (i_master && |o_grp_done);
	COV_SLAVE_GROUP: cover property (!i_master && |o_grp_done);
	COV_MULTI_WORD: cover property (r.st == MBSP_STORE ##1 r.st == MBSP_LOAD);
	COV_RETRIGGER: cover property (r.st == MBSP_IDLE && r.pend[0] && r.prev[0]);
endmodule : mbsp_core
`default_nettype wire

// ==== mbsp_peer.sv ====
// Purpose: external serial peripheral facing the master port
// Assumes: clock idles low, sample on rise, shift on fall
// Notes: one 32-bit reply streams across all words of a selection
`timescale 1ns/1ns
`default_nettype none
module mbsp_peer #(
	parameter logic [31:0] REPLY = 32'hC3A5_96E1
) (
	input wire logic i_sclk,
	input wire logic i_sel_n,
	input wire logic i_simo,
	output logic o_somi,
	output logic [31:0] o_got
);
	// ----
	// Behaviour
	// ----
	logic [31:0] sh;
	initial begin
		o_somi = 1'b0;
		o_got = 32'h0;
		sh = 32'h0;
	end
	// First bit must be ready before the first clock edge
	always @(negedge i_sel_n) begin
		sh = REPLY;
		o_somi = sh[31];
		o_got = 32'h0;
	end
	// Released line must not keep the last bit
	always @(posedge i_sel_n) o_somi = ~o_somi;
	always @(posedge i_sclk) if (!i_sel_n) o_got = {o_got[30:0], i_simo};
	always @(negedge i_sclk) begin
		if (!i_sel_n) begin
			sh = sh << 1;
			o_somi = sh[31];
		end
	end
endmodule : mbsp_peer
`default_nettype wire

// ==== mbsp_pkg.sv ====
// Purpose: shared constants and types for the multibuffer serial port
// Assumes: 20 MHz port clock, 128-entry buffer memory
// Notes: pin indices address the four serial pins of the core
package mbsp_pkg;
	localparam int MBSP_NUM_BUF = 128;
	localparam int MBSP_IDX_W = 7;
	localparam int MBSP_WORD_W = 16;
	localparam int MBSP_DIV_W = 8;
	localparam int MBSP_NUM_SRC = 15;
	localparam logic [4:0] MBSP_LEN_MIN = 5'h02;
	localparam logic [4:0] MBSP_LEN_MAX = 5'h10;
	localparam logic [3:0] MBSP_SRC_NONE = 4'h0;
	// Pin indices
	localparam int MBSP_PIN_CLK = 0;
	localparam int MBSP_PIN_SIMO = 1;
	localparam int MBSP_PIN_SOMI = 2;
	localparam int MBSP_PIN_CS = 3;
	localparam int MBSP_NUM_PIN = 4;
	// Buffer field select
	localparam logic [1:0] MBSP_FLD_TX = 2'h0;
	localparam logic [1:0] MBSP_FLD_RX = 2'h1;
	localparam logic [1:0] MBSP_FLD_CTRL = 2'h2;
	localparam logic [1:0] MBSP_FLD_STAT = 2'h3;
	// Control field layout: [4:0] word length, [5] clock idle level
	localparam int MBSP_CTRL_LEN_LSB = 0;
	localparam int MBSP_CTRL_CPOL = 5;
	// Status field written when a word completes
	localparam logic [15:0] MBSP_STAT_DONE = 16'h0001;
	typedef enum logic [1:0] {MBSP_IDLE, MBSP_LOAD, MBSP_SHIFT, MBSP_STORE} mbsp_state_t;
	typedef struct packed {
		logic [3:0] src;
		logic evt_low;
		logic [6:0] first;
		logic [6:0] last;
	} mbsp_grp_cfg_t;
endpackage : mbsp_pkg

// ==== mbsp_sync3.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clock
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module mbsp_sync3 #(
	parameter int W = 1
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	import mbsp_pkg::*;
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} mbsp_sync_t;
	mbsp_sync_t r;
	mbsp_sync_t n;
	always_comb begin
		n = r;
		n.s1 = i_async;
		n.s2 = r.s1;
		n.s3 = r.s2;
		for (int b = 0; b < W; b++) begin
			if (r.s2[b] == r.s3[b]) begin
				n.lvl[b] = r.s3[b];
			end
		end
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign o_level = r.lvl;
endmodule : mbsp_sync3
`default_nettype wire

// ==== test_mbsp_core.sv ====
// Purpose: self-checking bench for the multibuffer serial port core
// Assumes: peer model on the pins, buffer port driven directly
// Notes: slave traffic uses an unrelated 400 ns serial clock
`timescale 1ns/1ns
`default_nettype none
module test_mbsp_core;
	import mbsp_pkg::*;
	localparam logic [31:0] PAT = 32'hC3A5_96E1;
	localparam logic [7:0] SL_TX = 8'h5B;
	logic i_clock, i_reset, i_master, i_tick, i_buf_wr, o_busy, peer_somi;
	logic [7:0] i_baud_div, i_gio_a, q;
	logic [5:0] i_timer_ch;
	logic [6:0] i_buf_addr;
	logic [1:0] i_buf_field;
	logic [15:0] i_buf_wdata, o_buf_rdata, rd_v;
	logic [3:0] gen, gdir, gout, drv, pin, o_pin_out, o_pin_oe, o_pin_sync, o_grp_done;
	logic [31:0] got;
	mbsp_grp_cfg_t [3:0] cfg;
	int fails, samples_checked, n;
	// Wire level: the core wins where it drives
	assign pin = (o_pin_oe & o_pin_out) | (~o_pin_oe & {drv[3], peer_somi, drv[1:0]});
	mbsp_core u_mbsp_core (
		.i_clock(i_clock), .i_reset(i_reset), .i_master(i_master), .i_baud_div(i_baud_div),
		.i_grp_cfg(cfg), .i_gio_a(i_gio_a), .i_timer_ch(i_timer_ch), .i_tick(i_tick),
		.i_buf_wr(i_buf_wr), .i_buf_addr(i_buf_addr), .i_buf_field(i_buf_field), .i_buf_wdata(i_buf_wdata),
		.i_gpio_en(gen), .i_gpio_dir(gdir), .i_gpio_out(gout), .i_pin_in(pin),
		.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_sync(o_pin_sync),
		.o_buf_rdata(o_buf_rdata), .o_grp_done(o_grp_done), .o_busy(o_busy)
	);
	mbsp_peer #(.REPLY(PAT)) u_mbsp_peer (.i_sclk(pin[MBSP_PIN_CLK]), .i_sel_n(pin[MBSP_PIN_CS]),
		.i_simo(pin[MBSP_PIN_SIMO]), .o_somi(peer_somi), .o_got(got));
	// ----
	// Tasks
	// ----
	task automatic final_report;
		$display("checked %0d failed %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// A wait that used up its bound counts as a mismatch and ends the run
	task automatic tmo(input string nm, input int k, input int lim);
		if (k >= lim) begin
			chk(nm, 16'h0001, 16'h0000);
			final_report();
		end
	endtask : tmo
	task automatic cyc(input int k);
		repeat (k) @(negedge i_clock);
	endtask : cyc
	// Strobe drops a cycle before the next write may raise it
	task automatic wr(input logic [6:0] a, input logic [1:0] f, input logic [15:0] d);
		i_buf_addr = a;
		i_buf_field = f;
		i_buf_wdata = d;
		i_buf_wr = 1'b1;
		cyc(1);
		i_buf_wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [1:0] f);
		i_buf_addr = a;
		i_buf_field = f;
		cyc(1);
		rd_v = o_buf_rdata;
	endtask : rd
	task automatic wt(input int g);
		int k;
		k = 0;
		while (o_grp_done[g] !== 1'b1 && k < 3000) begin
			cyc(1);
			k++;
		end
		chk("group done", {15'h0, o_grp_done[g]}, 16'h1);
		if (k >= 3000) final_report();
	endtask : wt
	// ----
	// Sequence
	// ----
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	initial begin
		i_reset = 1'b1;
		i_master = 1'b1;
		// Half period must exceed the pin synchroniser delay so the answer bit has settled
		i_baud_div = 8'h05;
		i_gio_a = 8'h00;
		i_timer_ch = 6'h00;
		i_tick = 1'b0;
		i_buf_wr = 1'b0;
		i_buf_addr = 7'h00;
		i_buf_field = 2'h0;
		i_buf_wdata = 16'h0000;
		{gen, gdir, gout} = 12'h000;
		drv = 4'h8;
		cfg = '0;
		fails = 0;
		samples_checked = 0;
		cyc(20);
		chk("oe in reset", {12'h0, o_pin_oe}, 16'h0000);
		i_reset = 1'b0;
		cyc(2);
		chk("oe master", {12'h0, o_pin_oe}, 16'h000B);
		wr(7'h00, MBSP_FLD_TX, 16'h9A5C);
		wr(7'h00, MBSP_FLD_CTRL, 16'h0010);
		wr(7'h01, MBSP_FLD_TX, 16'h0013);
		wr(7'h01, MBSP_FLD_CTRL, 16'h0005);
		wr(7'h02, MBSP_FLD_TX, 16'h0001);
		wr(7'h02, MBSP_FLD_CTRL, 16'h0022);
		wr(7'h04, MBSP_FLD_TX, 16'h00C6);
		wr(7'h04, MBSP_FLD_CTRL, 16'h0008);
		wr(7'h7F, MBSP_FLD_TX, 16'hBEEF);
		rd(7'h00, MBSP_FLD_TX);
		chk("tx0", rd_v, 16'h9A5C);
		rd(7'h7F, MBSP_FLD_TX);
		chk("tx127", rd_v, 16'hBEEF);
		$display("test buffer done");
		cfg[0] = '{4'h3, 1'b0, 7'h00, 7'h01};
		cyc(8);
		i_gio_a[2] = 1'b1;
		n = 0;
		while (o_pin_out[MBSP_PIN_CLK] !== 1'b1 && n < 500) begin
			cyc(1);
			n++;
		end
		tmo("clock start", n, 500);
		n = 0;
		while (o_pin_out[MBSP_PIN_CLK] === 1'b1 && n < 500) begin
			cyc(1);
			n++;
		end
		tmo("clock stop", n, 500);
		chk("half period", n[15:0], 16'h0006);
		wt(0);
		chk("peer w0", got[20:5], 16'h9A5C);
		chk("peer w1", {11'h0, got[4:0]}, 16'h0013);
		rd(7'h01, MBSP_FLD_RX);
		chk("rx1", rd_v, {11'h0, PAT[15:11]});
		rd(7'h00, MBSP_FLD_STAT);
		chk("stat0", rd_v, MBSP_STAT_DONE);
		wr(7'h00, MBSP_FLD_RX, 16'h0000);
		rd(7'h00, MBSP_FLD_RX);
		chk("rx0", rd_v, PAT[31:16]);
		chk("cs idle", {15'h0, o_pin_out[MBSP_PIN_CS]}, 16'h0001);
		cfg[0] = '0;
		i_gio_a = 8'h00;
		$display("test master done");
		for (int c = 1; c < 16; c++) begin
			cfg[1] = '{c[3:0], 1'b0, 7'h02, 7'h02};
			cyc(8);
			if (c < 9) i_gio_a[c-1] = 1'b1;
			else if (c < 15) i_timer_ch[c-9] = 1'b1;
			else i_tick = 1'b1;
			wt(1);
			{i_gio_a, i_timer_ch, i_tick} = 15'h0000;
		end
		$display("test sources done");
		chk("clk idle high", {15'h0, o_pin_out[MBSP_PIN_CLK]}, 16'h0001);
		cfg = '0;
		cfg[2].evt_low = 1'b1;
		n = 0;
		for (int k = 0; k < 40; k++) begin
			{i_gio_a, i_timer_ch, i_tick} = {15{k[2]}};
			cyc(1);
			if (o_busy !== 1'b0) n++;
		end
		chk("busy count", n[15:0], 16'h0000);
		i_gio_a = 8'hFF;
		cfg[0] = '{4'h1, 1'b1, 7'h02, 7'h02};
		cyc(8);
		i_gio_a[0] = 1'b0;
		wt(0);
		i_gio_a[0] = 1'b1;
		// Runs armed while the level was low still finish before the group is torn down
		cyc(80);
		chk("idle on high level", {15'h0, o_busy}, 16'h0000);
		cfg[0] = '0;
		$display("test events done");
		gen = 4'hA;
		gdir = 4'hA;
		gout = 4'h2;
		cyc(2);
		chk("gp oe", {12'h0, o_pin_oe & 4'hA}, 16'h000A);
		chk("gp out", {15'h0, o_pin_out[MBSP_PIN_CS]}, 16'h0000);
		chk("gp out1", {15'h0, o_pin_out[MBSP_PIN_SIMO]}, 16'h0001);
		gdir = 4'h0;
		drv[3] = 1'b0;
		cyc(8);
		chk("gp in", {15'h0, o_pin_sync[MBSP_PIN_CS]}, 16'h0000);
		gen = 4'h0;
		drv[3] = 1'b1;
		$display("test gpio done");
		i_master = 1'b0;
		{i_gio_a, i_timer_ch, i_tick} = 15'h0000;
		wr(7'h04, MBSP_FLD_STAT, 16'h0000);
		cfg[1] = '{4'hF, 1'b0, 7'h04, 7'h04};
		cyc(8);
		i_tick = 1'b1;
		n = 0;
		while (o_busy !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		tmo("slave start", n, 100);
		cyc(4);
		drv[3] = 1'b0;
		#200;
		for (int b = 7; b >= 0; b--) begin
			drv[1] = SL_TX[b];
			#200 drv[0] = 1'b1;
			#200 q[b] = pin[MBSP_PIN_SOMI];
			drv[0] = 1'b0;
		end
		#200 drv[3] = 1'b1;
		cyc(20);
		chk("slave somi", {8'h0, q}, 16'h00C6);
		rd(7'h04, MBSP_FLD_RX);
		chk("slave rx", rd_v, {8'h0, SL_TX});
		rd(7'h04, MBSP_FLD_STAT);
		chk("slave stat", rd_v, MBSP_STAT_DONE);
		$display("test slave done");
		final_report();
	end
endmodule : test_mbsp_core
`default_nettype wire
